// ==== src/rtc_cmd.sv ====
// Behaviour
// R01: Config power-up runs self-test over stored count
// R02: All switches off means config mode
// R03: Test count accepts 0 through 32
// R04: Count zero skips self-test
// R05: Test count resets to four
// R06: Set-count command works in both modes
// R07: Host sends 254,50,146,count to set
// R08: Acknowledge completed set/restore with 85
// R09: 254,50,145 returns current count byte
// R10: Step every counted bank, heartbeat waits
// R11: Restore 254,50,144 only in config mode
// R12: Restore device number, refresh, timing 26576
// R13: Restore reps 1, gap 35, report, banks 32
// R14: Host should keep count one or more
// R15: Runtime mode ignores restore command
`timescale 1ns/1ps
`default_nettype none
module rtc_cmd
  import rtc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [7:0] DIP_SW,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] TEST_BANK,
  output logic TEST_ACTIVE,
  output logic HEARTBEAT_EN
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  // Each access completes in its second access cycle
  wire acc = PSEL && PENABLE && !PREADY;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire hit_rx = PADDR == ADDR_RX;
  wire hit_tx = PADDR == ADDR_TX;
  wire hit_stat = PADDR == ADDR_STAT;
  wire hit_cfg = PADDR == ADDR_CFG;
  wire hit_param = PADDR == ADDR_PARAM;
  wire hit_timing = PADDR == ADDR_TIMING;
  wire mapped = hit_rx | hit_tx | hit_stat | hit_cfg | hit_param | hit_timing;

  // ==========================================================
  // State
  // ==========================================================
  rtc_state_t state;
  rtc_params_t prm;
  logic [5:0] test_count;
  logic config_mode;
  logic [5:0] bank;
  logic [7:0] step;
  logic [7:0] rx_byte;
  logic rx_full;
  logic [7:0] tx_byte;
  logic tx_valid;

  // Mode strap read straight from the pins, so the start step sees it at once
  wire strap_cfg = DIP_SW == 8'h00; // [R02]
  // A byte is consumed when the parser is out of the start and self-test states
  wire take = rx_full && (state != ST_SELFTEST) && (state != ST_START);
  wire set_done = take && state == ST_VALUE;
  wire code_in = take && state == ST_CODE;
  // Values above 32 are clipped so the count stays legal
  wire [5:0] new_count = (rx_byte > 8'(TEST_MAX)) ? TEST_MAX : rx_byte[5:0]; // [R03]
  wire do_restore = code_in && rx_byte == CMD_RESTORE && config_mode; // [R11] [R15]
  wire do_read = code_in && rx_byte == CMD_READ_TEST; // [R09]
  wire do_ack = (set_done || do_restore) && prm.report; // [R08]
  wire tx_load = do_ack || do_read;
  wire [7:0] tx_next = do_read ? {2'b00, test_count} : ACK_BYTE;
  wire last_bank = bank + 6'd1 >= test_count;
  wire step_end = step == BANK_STEP_CYC - 8'd1;
  wire tx_pop = rd && hit_tx && tx_valid;

  // ==========================================================
  // Command parser
  // ==========================================================
  rtc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_START: begin
        // Mode and self-test chosen once after reset
        if (strap_cfg && test_count != 6'd0) begin // [R01] [R04]
          next_state = ST_SELFTEST;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_SELFTEST: begin
        if (step_end && last_bank) begin // [R10]
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take && rx_byte == CMD_LEAD) begin // [R07]
          next_state = ST_GROUP;
        end
      end
      ST_GROUP: begin
        if (take) begin
          next_state = (rx_byte == CMD_SETUP) ? ST_CODE : ST_IDLE;
        end
      end
      ST_CODE: begin
        if (take) begin
          next_state = (rx_byte == CMD_SET_TEST) ? ST_VALUE : ST_IDLE; // [R06]
        end
      end
      ST_VALUE: begin
        if (take) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Parser state; a low clock enable freezes it mid-command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state <= ST_START;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // Mode strap caught on the first enabled edge after reset
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      config_mode <= 1'b0;
    end else if (CLK_EN && state == ST_START) begin
      config_mode <= strap_cfg; // [R02]
    end
  end

  // ==========================================================
  // Self-test walker
  // ==========================================================
  // Walks every counted bank even if not fitted
  // Nothing marks a bank as fitted, so a large count simply takes longer
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bank <= 6'd0;
      step <= 8'd0;
    end else if (CLK_EN && state == ST_SELFTEST) begin
      step <= step_end ? 8'd0 : step + 8'd1;
      if (step_end) begin
        bank <= bank + 6'd1; // [R10]
      end
    end
  end

  // ==========================================================
  // Parameters
  // ==========================================================
  // Restore wins over bus writes in the same cycle
  // Reset reloads the same defaults as the restore command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      test_count <= TEST_RST; // [R05]
      prm <= '{DEVNUM_RST, 1'b1, TIMING_RST, REPS_RST, GAP_RST, 1'b1, ATTACHED_RST};
    end else if (CLK_EN) begin
      if (set_done) begin
        test_count <= new_count; // [R06]
      end
      if (do_restore) begin
        prm <= '{DEVNUM_RST, 1'b1, TIMING_RST, REPS_RST, GAP_RST, 1'b1, ATTACHED_RST}; // [R12] [R13]
      end else if (wr && hit_param && config_mode) begin
        prm.dev_num <= PWDATA[7:0];
        prm.reps <= PWDATA[15:8];
        prm.inter_byte_gap_setting <= PWDATA[23:16];
        prm.attached <= PWDATA[29:24];
        prm.auto_refresh <= PWDATA[30];
        prm.report <= PWDATA[31];
      end else if (wr && hit_timing && config_mode) begin
        prm.timing <= PWDATA[15:0];
      end
    end
  end

  // ==========================================================
  // Byte channels
  // ==========================================================
  // Receive holder; a write while full is dropped
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_byte <= 8'h0000;
      rx_full <= 1'b0;
    end else if (CLK_EN) begin
      if (wr && hit_rx && !rx_full) begin
        rx_byte <= PWDATA[7:0];
        rx_full <= 1'b1;
      end else if (take) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Reply holder; a new reply overwrites, load beats the pop
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tx_byte <= 8'h0000;
      tx_valid <= 1'b0;
    end else if (CLK_EN) begin
      if (tx_load) begin
        tx_byte <= tx_next; // [R08] [R09]
        tx_valid <= 1'b1;
      end else if (tx_pop) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // APB answer and outputs
  // ==========================================================
  // Read mux; unmapped addresses read zero and flag an error
  wire [31:0] rd_mux =
    hit_tx ? {23'd0, tx_valid, tx_byte} :
    hit_stat ? {22'd0, state, config_mode, tx_valid, rx_full,
                state == ST_SELFTEST} :
    hit_cfg ? {26'd0, test_count} :
    hit_param ? {prm.report, prm.auto_refresh, prm.attached, prm.inter_byte_gap_setting,
                 prm.reps, prm.dev_num} :
    hit_timing ? {16'd0, prm.timing} : 32'h0000_0000;

  // One wait state: ready follows the access cycle by one edge
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      PREADY <= acc;
      PSLVERR <= acc && !mapped;
      PRDATA <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Pins come straight from flops; heartbeat stays dark while walking
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TEST_BANK <= 8'h0000;
      TEST_ACTIVE <= 1'b0;
      HEARTBEAT_EN <= 1'b0;
    end else if (CLK_EN) begin
      TEST_BANK <= {2'b00, bank};
      TEST_ACTIVE <= next_state == ST_SELFTEST;
      HEARTBEAT_EN <= next_state != ST_SELFTEST && next_state != ST_START; // [R10]
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  // Each check but a_ready_pulse is tagged with the rule it guards
  a_count_range: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R03]
    test_count <= TEST_MAX) else $error("test count above 32");
  a_set_count: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R06]
    CLK_EN && set_done |=> test_count == $past(new_count)) else $error("set lost");
  a_ack_byte: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R08]
    CLK_EN && do_ack && !do_read |=> tx_valid && tx_byte == 8'h0055) else $error("no ack");
  a_read_reply: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R09]
    CLK_EN && do_read |=> tx_byte == {2'b00, test_count}) else $error("bad read reply");
  a_runtime_keep: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R15]
    !config_mode && state != ST_START |=> prm == $past(prm)) else $error("runtime change");
  a_restore_vals: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R12] [R13]
    CLK_EN && do_restore |=> prm.timing == 16'h67D0 && prm.reps == 8'h0001 &&
    prm.inter_byte_gap_setting == 8'h0023) else $error("restore values");
  a_restore_flags: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R12] [R13]
    CLK_EN && do_restore |=> prm.dev_num == 8'h00 && prm.auto_refresh && prm.report &&
    prm.attached == 6'h20) else $error("restore flags");
  a_zero_skip: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R04]
    CLK_EN && state == ST_START && !(strap_cfg && test_count != 6'd0) |=> state == ST_IDLE)
    else $error("self-test not skipped");
  a_test_entry: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R01]
    CLK_EN && state == ST_START && strap_cfg && test_count != 6'd0 |=> state == ST_SELFTEST)
    else $error("self-test not entered");
  a_mode_strap: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R02]
    CLK_EN && state == ST_START |=> config_mode == ($past(DIP_SW) == 8'h00))
    else $error("mode strap wrong");
  a_walk_all: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R10]
    state == ST_SELFTEST |-> bank < test_count)
    else $error("walker passed the count");
  a_ready_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CLK_EN && PREADY |=> !PREADY) else $error("ready held over");
  a_no_hb_test: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R10]
    TEST_ACTIVE |-> !HEARTBEAT_EN) else $error("heartbeat during test");
endmodule
`default_nettype wire

// ==== src/rtc_pkg.sv ====
package rtc_pkg;
  // Command framing bytes and the acknowledge reply byte
  localparam logic [7:0] CMD_LEAD = 8'h00FE;
  localparam logic [7:0] CMD_SETUP = 8'h0032;
  localparam logic [7:0] CMD_SET_TEST = 8'h0092;
  localparam logic [7:0] CMD_READ_TEST = 8'h0091;
  localparam logic [7:0] CMD_RESTORE = 8'h0090;
  localparam logic [7:0] ACK_BYTE = 8'h0055;
  // Limits and reset values
  localparam logic [5:0] TEST_MAX = 6'h0020;
  localparam logic [5:0] TEST_RST = 6'h0004;
  localparam logic [7:0] DEVNUM_RST = 8'h0000;
  localparam logic [15:0] TIMING_RST = 16'h67D0;
  localparam logic [7:0] REPS_RST = 8'h0001;
  localparam logic [7:0] GAP_RST = 8'h0023;
  localparam logic [5:0] ATTACHED_RST = 6'h0020;
  // Cycles each bank step of the self-test takes
  localparam int BANK_STEP_NS = 1000;
  localparam int CLK_NS = 100;
  localparam logic [7:0] BANK_STEP_CYC = 8'(BANK_STEP_NS / CLK_NS);
  // APB map
  localparam logic [7:0] ADDR_RX = 8'h0000;
  localparam logic [7:0] ADDR_TX = 8'h0004;
  localparam logic [7:0] ADDR_STAT = 8'h0008;
  localparam logic [7:0] ADDR_CFG = 8'h000C;
  localparam logic [7:0] ADDR_PARAM = 8'h0010;
  localparam logic [7:0] ADDR_TIMING = 8'h0014;

  typedef enum logic [5:0] {
    ST_SELFTEST = 6'b00_0001,
    ST_IDLE = 6'b00_0010,
    ST_GROUP = 6'b00_0100,
    ST_CODE = 6'b00_1000,
    ST_VALUE = 6'b01_0000,
    ST_START = 6'b10_0000
  } rtc_state_t;

  typedef struct packed {
    logic [7:0] dev_num;
    logic auto_refresh;
    logic [15:0] timing;
    logic [7:0] reps;
    logic [7:0] inter_byte_gap_setting;
    logic report;
    logic [5:0] attached;
  } rtc_params_t;
endpackage

// ==== dv/rtc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host model: issues APB transfers carrying command bytes
module rtc_host
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic tmo
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tmo = 1'b0;
  end

  // One APB transfer; ready and read data are taken at the edge that sees ready high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo <= 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Command frame: lead, setup group, code, optional value byte
  task automatic cmd(input logic [7:0] code, input logic [7:0] val, input logic has_val);
    logic [31:0] q;
    logic e;
    xfer(1'b1, ADDR_RX, {24'h00_0000, CMD_LEAD}, q, e);
    xfer(1'b1, ADDR_RX, {24'h00_0000, CMD_SETUP}, q, e);
    xfer(1'b1, ADDR_RX, {24'h00_0000, code}, q, e);
    if (has_val) xfer(1'b1, ADDR_RX, {24'h00_0000, val}, q, e);
  endtask
endmodule
`default_nettype wire

// ==== dv/relay_test_config_commands_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Testbench top
module relay_test_config_commands_test
  import rtc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] dip_sw = 8'h00;
  logic clk_en = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, tmo, test_active, heartbeat_en;
  logic [7:0] paddr, test_bank;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int fails = 0;
  int check_count = 0;

  rtc_cmd dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .DIP_SW(dip_sw),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TEST_BANK(test_bank),
    .TEST_ACTIVE(test_active), .HEARTBEAT_EN(heartbeat_en));
  rtc_host host (.clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .tmo(tmo));

  // 10 MHz clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Reset for two edges with the switch setting that picks the mode
  task automatic rst(input logic [7:0] dip);
    sys_rst <= 1'b1;
    dip_sw <= dip;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask

  // Count self-test cycles; heartbeat must stay dark while banks are stepped
  task automatic watch(input int exp_n);
    int n, ovl, k;
    n = 0;
    ovl = 0;
    for (k = 0; k < 3000; k++) begin
      @(negedge sys_clk);
      if (test_active === 1'b1) n++;
      if (test_active === 1'b1 && heartbeat_en !== 1'b0) ovl++;
      if (k > 4 && test_active !== 1'b1) break;
    end
    chk(32'(k < 3000), 32'h0000_0001);
    chk(32'(n), 32'(exp_n));
    chk(32'(ovl), 32'h0000_0000);
    if (k >= 3000) results;
  endtask

  // A hung transfer ends the run
  always @(posedge tmo) begin
    fails++;
    results;
  end

  // ==========
  // Main sequence
  initial begin
    rst(8'h00);
    // Freeze the block for six edges mid-walk; the walk must stretch by as much
    fork
      watch(4 * int'(BANK_STEP_CYC) + 6);
      begin
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (6) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    host.cmd(CMD_READ_TEST, 8'h00, 1'b0);
    rd(ADDR_TX, 32'h0000_0104);
    chk(32'(heartbeat_en), 32'h0000_0001);
    chk(32'(test_bank), 32'h0000_0004);
    host.cmd(CMD_SET_TEST, 8'h00, 1'b1);
    rd(ADDR_TX, 32'h0000_0155);
    rd(ADDR_CFG, 32'h0000_0000);
    host.cmd(CMD_SET_TEST, 8'h20, 1'b1);
    rd(ADDR_CFG, 32'h0000_0020);
    host.cmd(CMD_SET_TEST, 8'h28, 1'b1);
    rd(ADDR_CFG, 32'h0000_0020);
    host.cmd(CMD_READ_TEST, 8'h00, 1'b0);
    rd(ADDR_TX, 32'h0000_0120);
    host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk(32'(e), 32'h0000_0001);
    // Scramble parameters so the restore has something to undo
    host.xfer(1'b1, ADDR_PARAM, 32'h0000_0000, q, e);
    host.xfer(1'b1, ADDR_TIMING, 32'h0000_0000, q, e);
    rd(ADDR_PARAM, 32'h0000_0000);
    // Reporting off: a set is taken silently and the old reply stays invalid
    host.cmd(CMD_SET_TEST, 8'h20, 1'b1);
    rd(ADDR_TX, 32'h0000_0020);
    host.xfer(1'b1, ADDR_PARAM, 32'h8000_0000, q, e);
    rd(ADDR_PARAM, 32'h8000_0000);
    host.cmd(CMD_RESTORE, 8'h00, 1'b0);
    rd(ADDR_TX, 32'h0000_0155);
    rd(ADDR_PARAM, 32'hE023_0100);
    rd(ADDR_TIMING, 32'h0000_67D0);
    rd(ADDR_STAT, 32'h0000_0028);
    // Runtime mode: no self-test, parameters protected, restore ignored
    rst(8'h01);
    watch(0);
    host.xfer(1'b1, ADDR_PARAM, 32'h0000_0000, q, e);
    rd(ADDR_PARAM, 32'hE023_0100);
    host.cmd(CMD_RESTORE, 8'h00, 1'b0);
    rd(ADDR_TX, 32'h0000_0000);
    host.cmd(CMD_SET_TEST, 8'h07, 1'b1);
    rd(ADDR_TX, 32'h0000_0155);
    rd(ADDR_CFG, 32'h0000_0007);
    results;
  end
endmodule
`default_nettype wire
